/* dv/eeprom_host_chk.sv */
/*
 Concurrent checks on the host controller's pin and request ports.
 Assumes one clock domain and the bind at the foot of this file.
*/
`timescale 1ns/1ps
`default_nettype none
module eeprom_host_chk
   import eeprom_host_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic req_valid,
   input wire cmd_t req_cmd,
   input wire logic [12:0] req_addr,
   input wire logic [7:0] req_data,
   input wire logic req_last,
   input wire logic req_prefix,
   input wire logic req_ready,
   input wire logic [7:0] rsp_data,
   input wire logic rsp_valid,
   input wire logic busy,
   input wire logic timeout,
   input wire logic [12:0] address_pins,
   input wire logic [7:0] data_pins_i,
   input wire logic [7:0] data_pins_o,
   input wire logic [7:0] data_pins_oe,
   input wire logic chip_sel_n,
   input wire logic out_en_n,
   input wire logic wr_strobe_n
);
   // One domain, so clock and reset are given once
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);

   a_write_frame: assert property (
      !wr_strobe_n |-> out_en_n && !chip_sel_n)
      else $error("write strobe low outside a write frame");
   a_write_drive: assert property (
      !wr_strobe_n |-> data_pins_oe == 8'hff)
      else $error("data not driven during write strobe");
   a_strobe_width: assert property (
      $fell(wr_strobe_n) |-> !wr_strobe_n [*2])
      else $error("write strobe pulse too short");
   a_addr_hold: assert property (
      !wr_strobe_n && !$past(wr_strobe_n) |-> $stable(address_pins))
      else $error("address moved while strobe low");
   a_data_latch: assert property (
      $rose(wr_strobe_n) |-> $stable(data_pins_o))
      else $error("data moved at strobe rising edge");
   a_read_frame: assert property (
      !out_en_n |-> !chip_sel_n && wr_strobe_n && data_pins_oe == 8'h00)
      else $error("read frame malformed or bus contention");
   a_busy_quiet: assert property (
      busy |-> wr_strobe_n && (!req_ready || req_cmd == cmd_poll))
      else $error("access started during programming guard");
   a_read_starts: assert property (
      req_valid && req_ready && req_cmd == cmd_read |-> ##[1:8] !out_en_n)
      else $error("read request gave no read cycle");
   a_write_starts: assert property (
      req_valid && req_ready && req_cmd == cmd_write && !req_prefix
      |-> ##[1:8] !wr_strobe_n)
      else $error("write request gave no write strobe");
endmodule

bind eeprom_host eeprom_host_chk u_chk (
   .clk(clk), .arst_n(arst_n), .req_valid(req_valid), .req_cmd(req_cmd),
   .req_addr(req_addr), .req_data(req_data), .req_last(req_last),
   .req_prefix(req_prefix), .req_ready(req_ready), .rsp_data(rsp_data),
   .rsp_valid(rsp_valid), .busy(busy), .timeout(timeout),
   .address_pins(address_pins), .data_pins_i(data_pins_i),
   .data_pins_o(data_pins_o), .data_pins_oe(data_pins_oe),
   .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .wr_strobe_n(wr_strobe_n)
);
`default_nettype wire

/* dv/eeprom_host_test.sv */
/*
 Self-checking bench for the EEPROM host controller against the device
 model. Assumes a 20 MHz clock and a shortened programming guard.
*/
`timescale 1ns/1ps
`default_nettype none
module eeprom_host_test;
   import eeprom_host_pkg::*;
   localparam int LOAD = 3000;
   logic clk = 1'b0, arst_n = 1'b0, slow = 1'b0;
   logic req_valid = 1'b0, req_last = 1'b0, req_prefix = 1'b0;
   cmd_t req_cmd = cmd_read;
   logic [12:0] req_addr = 13'h0000, address_pins;
   logic [7:0] req_data = 8'h00, rsp_data, data_pins_i, data_pins_o;
   logic [7:0] data_pins_oe, mdl_q, bus_last = 8'h00;
   logic req_ready, rsp_valid, busy, timeout, chip_sel_n, out_en_n;
   logic wr_strobe_n, mdl_oe;
   int mismatches = 0, samples_checked = 0;

   always #25 clk = !clk;

   eeprom_host #(.WRITE_CYCLE_CYC(200)) i_dut (.clk(clk), .arst_n(arst_n),
      .req_valid(req_valid), .req_cmd(req_cmd), .req_addr(req_addr),
      .req_data(req_data), .req_last(req_last), .req_prefix(req_prefix),
      .req_ready(req_ready), .rsp_data(rsp_data), .rsp_valid(rsp_valid),
      .busy(busy), .timeout(timeout), .address_pins(address_pins),
      .data_pins_i(data_pins_i), .data_pins_o(data_pins_o),
      .data_pins_oe(data_pins_oe), .chip_sel_n(chip_sel_n),
      .out_en_n(out_en_n), .wr_strobe_n(wr_strobe_n));
   eeprom_model #(.LOAD_CYC(LOAD)) i_mem (.clk(clk), .slow(slow),
      .address_pins(address_pins), .data_in(data_pins_i), .ce_n(chip_sel_n),
      .oe_n(out_en_n), .we_n(wr_strobe_n), .data_out(mdl_q), .data_oe(mdl_oe));

   // Released bus shows a changing pattern, never the last byte
   assign data_pins_i = mdl_oe ? mdl_q
      : (|data_pins_oe ? data_pins_o : ~bus_last);
   always @(posedge clk) bus_last <= data_pins_i;

   task automatic check(input string what, input logic [7:0] seen,
                        input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Request held from a falling edge until a rising edge takes it
   task automatic send(input cmd_t c, input logic [12:0] a,
                       input logic [7:0] d, input logic last,
                       input logic pre);
      int n;
      n = 0;
      @(negedge clk);
      req_valid = 1'b1;
      req_cmd = c;
      req_addr = a;
      req_data = d;
      req_last = last;
      req_prefix = pre;
      while (req_ready !== 1'b1 && n < 20000) begin
         @(negedge clk);
         n++;
      end
      if (n == 20000) check("ready", 8'h00, 8'h01);
      @(negedge clk);
      req_valid = 1'b0;
   endtask

   task automatic get(output logic [7:0] v, output logic to);
      int n;
      n = 0;
      while (rsp_valid !== 1'b1 && timeout !== 1'b1 && n < 5000) begin
         @(negedge clk);
         n++;
      end
      if (n == 5000) check("answer", 8'h00, 8'h01);
      to = (timeout === 1'b1);
      v = rsp_data;
   endtask

   task automatic rd(input string what, input logic [12:0] a,
                     input logic [7:0] exp);
      logic [7:0] v;
      logic to;
      send(cmd_read, a, 8'h00, 1'b0, 1'b0);
      get(v, to);
      check(what, v, exp);
   endtask

   // Poll again after each guard timeout until the device answers
   task automatic wait_done(input logic [12:0] a, input logic [7:0] d,
                            output logic seen_to);
      logic [7:0] v;
      logic to;
      seen_to = 1'b0;
      for (int k = 0; k < 40; k++) begin
         send(cmd_poll, a, d, 1'b0, 1'b0);
         get(v, to);
         if (!to) break;
         seen_to = 1'b1;
      end
      check("poll ended", {7'h00, to}, 8'h00);
      check("poll", v, d);
   endtask

   task automatic t_byte();
      logic to;
      send(cmd_write, 13'h0123, 8'h5a, 1'b1, 1'b0);
      // Guard must be running once the single-byte load has closed
      repeat (8) @(negedge clk);
      check("busy", {7'h00, busy}, 8'h01);
      wait_done(13'h0123, 8'h5a, to);
      rd("byte", 13'h0123, 8'h5a);
      $display("test byte write done");
   endtask

   // Out of order with a reload of one byte in the same page
   task automatic t_page();
      logic to;
      send(cmd_write, 13'h0045, 8'h11, 1'b0, 1'b0);
      send(cmd_write, 13'h0041, 8'h22, 1'b0, 1'b0);
      send(cmd_write, 13'h0045, 8'h33, 1'b1, 1'b0);
      wait_done(13'h0045, 8'h33, to);
      rd("reload", 13'h0045, 8'h33);
      rd("other", 13'h0041, 8'h22);
      rd("untouched", 13'h0043, 8'hff);
      $display("test page write done");
   endtask

   // Device slower than the guard: a timeout must show, then data
   task automatic t_slow();
      logic to;
      slow = 1'b1;
      send(cmd_write, 13'h0300, 8'h4c, 1'b1, 1'b0);
      wait_done(13'h0300, 8'h4c, to);
      check("timeout", {7'h00, to}, 8'h01);
      slow = 1'b0;
      rd("slow", 13'h0300, 8'h4c);
      $display("test slow device done");
   endtask

   task automatic t_lock();
      logic to;
      send(cmd_lock_on, 13'h0000, 8'h00, 1'b1, 1'b0);
      repeat (LOAD + 300) @(negedge clk);
      rd("cmd addr", 13'h1555, 8'hff);
      send(cmd_write, 13'h0200, 8'h77, 1'b1, 1'b0);
      repeat (LOAD + 300) @(negedge clk);
      rd("locked", 13'h0200, 8'hff);
      send(cmd_write, 13'h0201, 8'h66, 1'b1, 1'b1);
      wait_done(13'h0201, 8'h66, to);
      rd("prefixed", 13'h0201, 8'h66);
      $display("test write lock done");
   endtask

   task automatic end_of_test();
      $display("checked %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Watchdog sized well above the six programming cycles
   initial begin
      repeat (90000) @(posedge clk);
      mismatches++;
      end_of_test();
   end

   initial begin
      repeat (5) @(negedge clk);
      arst_n = 1'b1;
      t_byte();
      t_page();
      t_slow();
      t_lock();
      end_of_test();
   end
endmodule
`default_nettype wire

/* dv/eeprom_model.sv */
/*
 Behavioural byte-wide self-timed EEPROM with page buffer, polling status
 and write lock. Samples its pins on clk; no reset, contents persist.
*/
`timescale 1ns/1ps
`default_nettype none
module eeprom_model #(
   parameter int LOAD_CYC = 3000,
   parameter int FAST_CYC = 120,
   parameter int SLOW_CYC = 400
) (
   input wire logic clk,
   input wire logic slow,
   input wire logic [12:0] address_pins,
   input wire logic [7:0] data_in,
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic we_n,
   output logic [7:0] data_out,
   output logic data_oe
);
   logic [7:0] mem [0:8191];
   logic [7:0] page_buf [0:63];
   logic [63:0] loaded_q;
   logic [12:0] addr_q;
   logic [7:0] din_q, last_q;
   logic [6:0] page_q;
   logic [1:0] seq_q;
   logic wr_q, rd_q, loading_q, prog_q, armed_q, locked_q, prefix_q, tog_q;
   int load_cnt_q, prog_cnt_q;
   logic wr_on, rd_on;

   // Write needs both strobes low and output enable high
   // Pins seen only on clk, so glitches that miss every rising clk edge never write
   assign wr_on = !ce_n && !we_n && oe_n;
   assign rd_on = !ce_n && !oe_n && we_n;
   // Busy reads turn into status polls
   assign data_oe = rd_on;
   assign data_out = prog_q ? {~last_q[7], tog_q, last_q[5:0]}
      : mem[address_pins];

   // Shipped unlocked and erased
   initial begin
      for (int i = 0; i < 8192; i++) mem[i] = 8'hff;
      {loaded_q, seq_q, wr_q, rd_q, loading_q, prog_q} = '0;
      {armed_q, locked_q, prefix_q, tog_q, load_cnt_q, prog_cnt_q} = '0;
   end

   // Strobe edges, page load, command detection and programming
   always @(posedge clk) begin
      wr_q <= wr_on;
      rd_q <= rd_on;
      din_q <= data_in;
      if (wr_on && !wr_q) addr_q <= address_pins;
      if (rd_on && !rd_q && prog_q) tog_q <= !tog_q;
      if (!wr_on && wr_q && !prog_q) begin
         loading_q <= 1'b1;
         load_cnt_q <= 0;
         if (seq_q == 2'd0 && addr_q == 13'h1555
             && din_q == 8'haa) begin
            seq_q <= 2'd1;
         end else if (seq_q == 2'd1 && addr_q == 13'h0aaa
                      && din_q == 8'h55) begin
            seq_q <= 2'd2;
         end else if (seq_q == 2'd2 && addr_q == 13'h1555
                      && din_q == 8'ha0) begin
            seq_q <= 2'd0;
            armed_q <= 1'b1;
            prefix_q <= 1'b1;
         end else begin
            seq_q <= 2'd0;
            page_buf[addr_q[5:0]] <= din_q;
            loaded_q[addr_q[5:0]] <= 1'b1;
            page_q <= addr_q[12:6];
            last_q <= din_q;
         end
      end else if (loading_q) begin
         load_cnt_q <= load_cnt_q + 1;
         if (load_cnt_q == LOAD_CYC - 1) begin
            loading_q <= 1'b0;
            prog_q <= 1'b1;
            prog_cnt_q <= 0;
         end
      end
      if (prog_q) begin
         prog_cnt_q <= prog_cnt_q + 1;
         if (prog_cnt_q == (slow ? SLOW_CYC : FAST_CYC) - 1) begin
            prog_q <= 1'b0;
            // Locked without prefix: timer runs, nothing is stored
            for (int i = 0; i < 64; i++) begin
               if (loaded_q[i] && (!locked_q || prefix_q)) begin
                  mem[{page_q, i[5:0]}] <= page_buf[i];
               end
            end
            if (armed_q) locked_q <= 1'b1;
            {loaded_q, armed_q, prefix_q} <= '0;
         end
      end
   end
endmodule
`default_nettype wire

/* src/eeprom_host.sv */
/*
 Host-side controller driving a byte-wide self-timed EEPROM: reads, byte
 and page writes, end-of-write polling, and write-lock command prefixes.
 Assumes the device pins are wired straight to this block and that all
 inputs are synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_host_map.svh"

// Functional notes
// - Write cycle: strobe low with chip select low, output enable high.
// - Each further byte follows within 150 us of the previous; the host does not time this, st_load_wait waits with no limit.
// - Page bits A6 to A12 stay fixed through one page load.
// - Three command writes arm the lock after one programming time.
// - Locked device accepts writes prefixed by the command sequence.
// - Command sequences use page-load timing across two pages.
module eeprom_host
   import eeprom_host_pkg::*;
#(
   parameter int WRITE_CYCLE_CYC = `WRITE_CYCLE_CYC,
   parameter int MAX_PAGE = 64,
   parameter logic [12:0] CMD_ADDR0 = `CMD_ADDR0,
   parameter logic [12:0] CMD_ADDR1 = `CMD_ADDR1,
   parameter logic [12:0] CMD_ADDR2 = `CMD_ADDR2,
   parameter logic [7:0] CMD_DATA0 = `CMD_DATA0,
   parameter logic [7:0] CMD_DATA1 = `CMD_DATA1,
   parameter logic [7:0] CMD_LOCK_ON = `CMD_LOCK_ON
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic req_valid,
   input wire cmd_t req_cmd,
   input wire logic [12:0] req_addr,
   input wire logic [7:0] req_data,
   input wire logic req_last,
   input wire logic req_prefix,
   output logic req_ready,
   output logic [7:0] rsp_data,
   output logic rsp_valid,
   output logic busy,
   output logic timeout,
   output logic [12:0] address_pins,
   input wire logic [7:0] data_pins_i,
   output logic [7:0] data_pins_o,
   output logic [7:0] data_pins_oe,
   output logic chip_sel_n,
   output logic out_en_n,
   output logic wr_strobe_n
);
   localparam int TW = 24;
   localparam logic [TW-1:0] LOW_CYC = TW'(`STROBE_LOW_CYC);
   localparam logic [TW-1:0] HIGH_CYC = TW'(`STROBE_HIGH_CYC);
   localparam logic [TW-1:0] ACC_CYC = TW'(`READ_ACCESS_CYC);
   // Device idles a whole load window before programming starts
   localparam logic [TW-1:0] WC_CYC =
      TW'(WRITE_CYCLE_CYC + `BYTE_LOAD_WINDOW_CYC);

   typedef enum logic [3:0] {
      st_idle, st_setup, st_wr_low, st_wr_high, st_rd_wait, st_rd_gap,
      st_load_wait, st_poll_a, st_poll_b
   } state_t;

   state_t state_q;
   logic [1:0] pre_idx_q;
   logic pre_act_q;
   logic [12:0] pend_addr_q;
   logic [7:0] pend_data_q;
   logic pend_last_q;
   logic [12:0] last_addr_q;
   logic [7:0] last_data_q;
   logic [7:0] poll_prev_q;
   logic poll_first_q;
   logic [TW-1:0] wc_cnt_q;
   logic [6:0] page_cnt_q;
   logic t_load;
   logic [TW-1:0] t_val;
   logic t_done;
   logic lock_arm_q;

   // Prefix step decode, used once by the write issue path in st_setup
   function automatic logic [20:0] pre_word(input logic [1:0] i,
                                            input logic [7:0] d);
      case (i)
         2'd0: pre_word = {CMD_ADDR0, CMD_DATA0};
         2'd1: pre_word = {CMD_ADDR1, CMD_DATA1};
         default: pre_word = {CMD_ADDR2, d};
      endcase
   endfunction

   strobe_timer #(.W(TW)) u_tmr (
      .clk(clk),
      .arst_n(arst_n),
      .load(t_load),
      .value(t_val),
      .done(t_done)
   );

   // Timer loads on entry to every timed state
   always_comb begin
      t_load = 1'b0;
      t_val = LOW_CYC;
      case (state_q)
         st_setup: begin
            t_load = 1'b1;
            t_val = LOW_CYC;
         end
         st_wr_low: begin
            t_load = t_done;
            t_val = HIGH_CYC;
         end
         st_idle: begin
            t_load = req_valid && req_ready && req_cmd != cmd_write
               && req_cmd != cmd_lock_on;
            t_val = ACC_CYC;
         end
         st_poll_a: begin
            t_load = 1'b1;
            t_val = ACC_CYC;
         end
         st_rd_gap: begin
            t_load = 1'b0;
            t_val = ACC_CYC;
         end
         default: begin
            t_load = 1'b0;
            t_val = LOW_CYC;
         end
      endcase
   end

   // Sequencer; prefix bytes go out before user data with page timing
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= st_idle;
         pre_idx_q <= 2'd0;
         pre_act_q <= 1'b0;
         pend_addr_q <= 13'h0000;
         pend_data_q <= 8'h00;
         pend_last_q <= 1'b0;
         req_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_data <= 8'h00;
         timeout <= 1'b0;
         address_pins <= 13'h0000;
         data_pins_o <= 8'h00;
         data_pins_oe <= 8'h00;
         chip_sel_n <= 1'b1;
         out_en_n <= 1'b1;
         wr_strobe_n <= 1'b1;
         last_addr_q <= 13'h0000;
         last_data_q <= 8'h00;
         poll_prev_q <= 8'h00;
         poll_first_q <= 1'b0;
         page_cnt_q <= 7'd0;
      end else begin
         rsp_valid <= 1'b0;
         timeout <= 1'b0;
         case (state_q)
            st_idle: begin
               chip_sel_n <= 1'b1;
               out_en_n <= 1'b1;
               wr_strobe_n <= 1'b1;
               data_pins_oe <= 8'h00;
               // Only status polls are taken while the guard runs
               req_ready <= !busy
                  || (req_valid && req_cmd == cmd_poll);
               if (req_valid && req_ready) begin
                  req_ready <= 1'b0;
                  pend_addr_q <= req_addr;
                  pend_data_q <= req_data;
                  pend_last_q <= req_last || req_cmd == cmd_lock_on;
                  address_pins <= req_addr;
                  case (req_cmd)
                     cmd_write, cmd_lock_on: begin
                        // Lock arm is the bare prefix; data byte unused
                        pre_act_q <= req_prefix
                           || req_cmd == cmd_lock_on;
                        pre_idx_q <= 2'd0;
                        page_cnt_q <= 7'd0;
                        state_q <= st_setup;
                     end
                     cmd_poll: begin
                        poll_first_q <= 1'b1;
                        state_q <= st_poll_a;
                     end
                     default: begin
                        chip_sel_n <= 1'b0;
                        out_en_n <= 1'b0;
                        state_q <= st_rd_wait;
                     end
                  endcase
               end
            end
            st_setup: begin
               // Output enable high before any write strobe
               out_en_n <= 1'b1;
               chip_sel_n <= 1'b0;
               if (pre_act_q) begin
                  {address_pins, data_pins_o} <=
                     pre_word(pre_idx_q, CMD_LOCK_ON);
               end else begin
                  address_pins <= pend_addr_q;
                  data_pins_o <= pend_data_q;
               end
               data_pins_oe <= 8'hff;
               // Pulse spans three clocks, above the one-clock noise floor
               wr_strobe_n <= 1'b0;
               state_q <= st_wr_low;
            end
            st_wr_low: begin
               // Data and address stay put until strobe rises
               if (t_done) begin
                  wr_strobe_n <= 1'b1;
                  state_q <= st_wr_high;
               end
            end
            st_wr_high: begin
               if (t_done) begin
                  if (pre_act_q && pre_idx_q != 2'd2) begin
                     pre_idx_q <= pre_idx_q + 2'd1;
                     state_q <= st_setup;
                  end else if (pre_act_q) begin
                     pre_act_q <= 1'b0;
                     if (pend_last_q && lock_arm_q) begin
                        state_q <= st_idle;
                     end else begin
                        state_q <= st_setup;
                     end
                  end else begin
                     last_addr_q <= pend_addr_q;
                     last_data_q <= pend_data_q;
                     page_cnt_q <= page_cnt_q + 7'd1;
                     state_q <= st_load_wait;
                  end
               end
            end
            st_load_wait: begin
               // Next byte must come inside the load window, same page; only the page is checked, the wait is untimed
               chip_sel_n <= 1'b1;
               data_pins_oe <= 8'h00;
               req_ready <= !pend_last_q
                  && page_cnt_q < 7'(MAX_PAGE);
               if (req_valid && req_ready && req_cmd == cmd_write
                   && req_addr[12:`PAGE_SEL_LSB]
                      == pend_addr_q[12:`PAGE_SEL_LSB]) begin
                  req_ready <= 1'b0;
                  pend_addr_q <= req_addr;
                  pend_data_q <= req_data;
                  pend_last_q <= req_last;
                  state_q <= st_setup;
               end else if (pend_last_q || page_cnt_q >= 7'(MAX_PAGE)) begin
                  req_ready <= 1'b0;
                  state_q <= st_idle;
               end
            end
            st_rd_wait: begin
               if (t_done) begin
                  rsp_data <= data_pins_i;
                  rsp_valid <= 1'b1;
                  out_en_n <= 1'b1;
                  chip_sel_n <= 1'b1;
                  state_q <= st_idle;
               end
            end
            st_poll_a: begin
               // Read last written address for toggle and poll bits
               address_pins <= last_addr_q;
               chip_sel_n <= 1'b0;
               out_en_n <= 1'b0;
               state_q <= st_poll_b;
            end
            st_poll_b: begin
               if (t_done) begin
                  out_en_n <= 1'b1;
                  chip_sel_n <= 1'b1;
                  poll_prev_q <= data_pins_i;
                  poll_first_q <= 1'b0;
                  // Done when bit 6 is steady and bit 7 matches the written byte
                  if (!poll_first_q
                      && data_pins_i[`ALT_BIT] == poll_prev_q[`ALT_BIT]
                      && data_pins_i[`POLL_BIT]
                         == last_data_q[`POLL_BIT]) begin
                     rsp_data <= data_pins_i;
                     rsp_valid <= 1'b1;
                     state_q <= st_idle;
                  end else if (!busy && !poll_first_q) begin
                     timeout <= 1'b1;
                     state_q <= st_idle;
                  end else begin
                     state_q <= st_rd_gap;
                  end
               end
            end
            st_rd_gap: begin
               state_q <= st_poll_a;
            end
            default: state_q <= st_idle;
         endcase
      end
   end

   // Remembers a lock-arm request so the data phase is skipped
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         lock_arm_q <= 1'b0;
      end else if (state_q == st_idle && req_valid && req_ready) begin
         lock_arm_q <= req_cmd == cmd_lock_on;
      end
   end

   // Write-cycle guard timer; starts after the last byte or lock prefix, so it spans the load window
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wc_cnt_q <= '0;
         busy <= 1'b0;
      end else if ((state_q == st_load_wait
                    && (pend_last_q || page_cnt_q >= 7'(MAX_PAGE)))
                   || (state_q == st_wr_high && lock_arm_q
                       && pre_idx_q == 2'd2)) begin
         wc_cnt_q <= WC_CYC;
         busy <= 1'b1;
      end else if (wc_cnt_q != '0) begin
         wc_cnt_q <= wc_cnt_q - 1'b1;
         busy <= 1'b1;
      end else begin
         busy <= 1'b0;
      end
   end
endmodule
`default_nettype wire

/* src/eeprom_host_map.svh */
/*
 Timing counts, page geometry and lock command constants for the parallel
 EEPROM host controller. Assumes a 20 MHz system clock.
*/
`ifndef EEPROM_HOST_MAP_SVH
`define EEPROM_HOST_MAP_SVH

`define CLK_HZ 20000000
`define WRITE_CYCLE_MS 10
`define WRITE_CYCLE_CYC ((`WRITE_CYCLE_MS * `CLK_HZ) / 1000)
`define BYTE_LOAD_WINDOW_US 150
`define BYTE_LOAD_WINDOW_CYC ((`BYTE_LOAD_WINDOW_US * (`CLK_HZ / 1000000)))
`define STROBE_LOW_NS 100
`define STROBE_LOW_CYC ((`STROBE_LOW_NS * (`CLK_HZ / 1000000) + 999) / 1000)
`define STROBE_HIGH_NS 50
`define STROBE_HIGH_CYC ((`STROBE_HIGH_NS * (`CLK_HZ / 1000000) + 999) / 1000)
`define READ_ACCESS_NS 120
`define READ_ACCESS_CYC ((`READ_ACCESS_NS * (`CLK_HZ / 1000000) + 999) / 1000)
`define PAGE_SEL_LSB 6
`define CMD_ADDR0 13'h1555
`define CMD_ADDR1 13'h0aaa
`define CMD_ADDR2 13'h1555
`define CMD_DATA0 8'haa
`define CMD_DATA1 8'h55
`define CMD_LOCK_ON 8'ha0
`define POLL_BIT 7
`define ALT_BIT 6

`endif

/* src/eeprom_host_pkg.sv */
/*
 Types shared by the EEPROM host controller files.
 Assumes the map header is included by any user of the constants.
*/
package eeprom_host_pkg;
   typedef enum logic [1:0] {
      cmd_read,
      cmd_write,
      cmd_lock_on,
      cmd_poll
   } cmd_t;
endpackage

/* src/strobe_timer.sv */
/*
 Down counter used for strobe widths and access waits.
 Assumes one clock; load wins over counting.
*/
`timescale 1ns/1ps
`default_nettype none
module strobe_timer #(
   parameter int W = 24
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic load,
   input wire logic [W-1:0] value,
   output logic done
);
   logic [W-1:0] cnt_q;

   // Counts down to zero, done while zero
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_q <= '0;
      end else if (load) begin
         cnt_q <= value;
      end else if (cnt_q != '0) begin
         cnt_q <= cnt_q - 1'b1;
      end
   end

   // Done ignores load: callers derive load from done, so no loop
   assign done = (cnt_q == '0);
endmodule
`default_nettype wire
